// >>> inc/smpo_pkg.sv
// Constants and types shared by the supply modulated OTP programmer
package smpo_pkg;
  // Core clock
  localparam int unsigned CLK_MHZ       = 125;
  // Times in microseconds
  localparam int unsigned T_SETTLE_US   = 20_000;
  localparam int unsigned T_ADV_US      = 700;
  localparam int unsigned T_BIT0_US     = 1_700;
  localparam int unsigned T_BIT1_US     = 2_700;
  localparam int unsigned T_WIN_LO_US   = 200;
  localparam int unsigned T_WIN_01_US   = 1_200;
  localparam int unsigned T_WIN_12_US   = 2_200;
  localparam int unsigned T_WIN_HI_US   = 3_200;
  localparam int unsigned T_TIMEOUT_US  = 2_000_000;
  localparam int unsigned T_INH_BASE_US = 31_250;
  localparam int unsigned T_INH_STEP_US = 122;
  // Cycle counts derived from the times
  localparam int unsigned SETTLE_CYC    = T_SETTLE_US * CLK_MHZ;
  localparam int unsigned WIN_LO_CYC    = T_WIN_LO_US * CLK_MHZ;
  localparam int unsigned WIN_01_CYC    = T_WIN_01_US * CLK_MHZ;
  localparam int unsigned WIN_12_CYC    = T_WIN_12_US * CLK_MHZ;
  localparam int unsigned WIN_HI_CYC    = T_WIN_HI_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_CYC   = T_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned INH_BASE_CYC  = T_INH_BASE_US * CLK_MHZ;
  localparam int unsigned INH_STEP_CYC  = T_INH_STEP_US * CLK_MHZ;
  // Counter widths
  localparam int unsigned CNT_W         = 28;
  localparam int unsigned PER_W         = 24;
  // Oscillator divide: toggle every half of 1024 edges
  localparam int unsigned OSC_DIV       = 1024;
  localparam int unsigned OSC_HALF_W    = 9;
  // OTP array layout
  localparam int unsigned WORD_W        = 8;
  localparam int unsigned WORD_CNT      = 3;
  localparam int unsigned ADDR_W        = 2;
  localparam logic [1:0]  ADDR_A        = 2'h0;
  localparam logic [1:0]  ADDR_B        = 2'h1;
  localparam logic [1:0]  ADDR_C        = 2'h2;
  localparam logic [7:0]  WORD_RESET    = 8'h00;
  // Word A fields, bit 1 of the word is index 7
  localparam int unsigned INH_MSB       = 7;
  localparam int unsigned INH_LSB       = 1;
  localparam int unsigned CAL_POS       = 0;
  // Option reload sequencer
  localparam logic [2:0]  RL_START      = 3'h0;
  localparam logic [2:0]  RL_LAST       = 3'h3;
  localparam logic [2:0]  RL_IDLE       = 3'h4;

  typedef enum logic [2:0] {
    SMPO_IDLE     = 3'b000,
    SMPO_MEAS_OSC = 3'b001,
    SMPO_MEAS_INH = 3'b010,
    SMPO_WORD_A   = 3'b011,
    SMPO_WORD_B   = 3'b100,
    SMPO_WORD_C   = 3'b101
  } smpo_state_t;
endpackage

// >>> sim/smpo_assertions.sv
// Port-level checks for the OTP programmer
`timescale 1ns/1ns
module smpo_assertions
  import smpo_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC_P = 2000
)(
  input wire logic              CLK_IN,             // Clock
  input wire logic              RESET_N_IN,         // Reset, active low
  input wire logic              START_LVL_IN,       // Entry level
  input wire logic              STOP_LVL_IN,        // Stop level
  input wire logic              MOD_LVL_IN,         // Modulation
  input wire logic              PRESTORE_LVL_IN,    // Pre-store level
  input wire logic              STORE_LVL_IN,       // Store level
  input wire logic              RESET_PAD_IN,       // Pad level
  input wire logic              RESET_PAD_OUT,      // Pad drive
  input wire logic              RESET_PAD_OE_N_OUT, // Pad enable
  input wire logic              LOAD_EN_OUT,        // Supply load
  input wire smpo_state_t       STATE_OUT,          // Instruction state
  input wire logic [WORD_W-1:0] SHIFT_OUT,          // Shift register
  input wire logic              STOP_MODE_OUT,      // Stop mode
  input wire logic              REINIT_OUT          // Reinitialise pulse
);
  logic        meas;
  logic [31:0] quiet_reg;
  assign meas = (STATE_OUT == SMPO_MEAS_OSC) || (STATE_OUT == SMPO_MEAS_INH);
  // Saturates so it never wraps
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      quiet_reg <= 32'h0;
    else if ($rose(MOD_LVL_IN) || $rose(START_LVL_IN))
      quiet_reg <= 32'h0;
    else if (quiet_reg < 32'hffff_0000)
      quiet_reg <= quiet_reg + 32'h1;
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  sequence s_meas_steady;
    meas [*4];
  endsequence
  sequence s_commit;
    $rose(PRESTORE_LVL_IN) ##[1:300] $rose(STORE_LVL_IN);
  endsequence
  property p_entry;
    $rose(START_LVL_IN) && STATE_OUT != SMPO_MEAS_OSC
      |-> ##[1:3] (STATE_OUT == SMPO_MEAS_OSC && SHIFT_OUT == 8'h00);
  endproperty
  property p_range;
    STATE_OUT <= SMPO_WORD_C;
  endproperty
  property p_sat;
    STATE_OUT == SMPO_WORD_C && !START_LVL_IN && !$past(START_LVL_IN)
      |=> STATE_OUT inside {SMPO_WORD_C, SMPO_IDLE};
  endproperty
  property p_meas;
    s_meas_steady |-> !RESET_PAD_OE_N_OUT && LOAD_EN_OUT == RESET_PAD_OUT;
  endproperty
  property p_idle;
    (STATE_OUT == SMPO_IDLE) [*4] |-> !LOAD_EN_OUT && RESET_PAD_OE_N_OUT;
  endproperty
  property p_timeout;
    quiet_reg == TIMEOUT_CYC_P + 8 |-> STATE_OUT == SMPO_IDLE;
  endproperty
  property p_stop;
    $rose(STOP_LVL_IN) |-> ##[1:4] STATE_OUT == SMPO_IDLE;
  endproperty
  property p_commit;
    s_commit |-> ##[1:4] STATE_OUT == SMPO_IDLE;
  endproperty
  property p_reinit;
    $fell(RESET_PAD_IN) && RESET_PAD_OE_N_OUT && $past(RESET_PAD_OE_N_OUT) && STOP_MODE_OUT
      |-> ##[1:8] REINIT_OUT;
  endproperty
  property p_pulse;
    $rose(REINIT_OUT) |=> !REINIT_OUT;
  endproperty
  a_entry: assert property (p_entry)
    else $error("bad entry");
  a_range: assert property (p_range)
    else $error("state range");
  a_sat: assert property (p_sat)
    else $error("state five left");
  a_meas: assert property (p_meas)
    else $error("measure drive");
  a_idle: assert property (p_idle)
    else $error("idle drive");
  a_timeout: assert property (p_timeout)
    else $error("no timeout");
  a_stop: assert property (p_stop)
    else $error("stop ignored");
  a_commit: assert property (p_commit)
    else $error("store ignored");
  a_reinit: assert property (p_reinit)
    else $error("no reload");
  a_pulse: assert property (p_pulse)
    else $error("long reinit");
endmodule

bind smpo_programmer smpo_assertions #(.TIMEOUT_CYC_P(TIMEOUT_CYC_P)) chk_u (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .START_LVL_IN(START_LVL_IN),
  .STOP_LVL_IN(STOP_LVL_IN), .MOD_LVL_IN(MOD_LVL_IN), .PRESTORE_LVL_IN(PRESTORE_LVL_IN),
  .STORE_LVL_IN(STORE_LVL_IN), .RESET_PAD_IN(RESET_PAD_IN), .RESET_PAD_OUT(RESET_PAD_OUT),
  .RESET_PAD_OE_N_OUT(RESET_PAD_OE_N_OUT), .LOAD_EN_OUT(LOAD_EN_OUT), .STATE_OUT(STATE_OUT),
  .SHIFT_OUT(SHIFT_OUT), .STOP_MODE_OUT(STOP_MODE_OUT), .REINIT_OUT(REINIT_OUT)
);

// >>> sim/smpo_station.sv
// Test station model driving the supply levels and pad
`timescale 1ns/1ns
module smpo_station
  import smpo_pkg::*;
#(
  parameter int SETTLE = 50,  // Settle wait
  parameter int ADV    = 35,  // Advance gap
  parameter int BIT0   = 85,  // Zero gap
  parameter int BIT1   = 135  // One gap
)(
  input  wire logic clk_in,       // Core clock
  output logic      start_out,    // Start level
  output logic      stop_out,     // Stop level
  output logic      mod_out,      // Modulation
  output logic      prestore_out, // Pre-store level
  output logic      store_out,    // Store level
  output logic      pad_out       // Reset pad
);
  initial {start_out, stop_out, mod_out, prestore_out, store_out, pad_out} = 6'h0;
  task automatic lvl(ref logic s, input int n);
    @(negedge clk_in);
    s = 1'b1;
    repeat (n) @(negedge clk_in);
    s = 1'b0;
  endtask
  task automatic entry();
    lvl(start_out, 4);
  endtask
  task automatic settle();
    repeat (SETTLE + 10) @(negedge clk_in);
  endtask
  // pulse g cycles after the last
  task automatic gap(input int g);
    repeat (g - 1) @(negedge clk_in);
    mod_out = 1'b1;
    @(negedge clk_in);
    mod_out = 1'b0;
  endtask
  task automatic open(input smpo_state_t st);
    entry();
    settle();
    gap(1);
    repeat (int'(st) - 1) gap(ADV);
  endtask
  // data goes in least significant first
  task automatic load(input smpo_state_t st, input logic [7:0] d);
    open(st);
    for (int i = 0; i < 8; i++)
      gap(d[i] ? BIT1 : BIT0);
  endtask
  task automatic commit();
    repeat (20) @(negedge clk_in);
    lvl(prestore_out, 3);
    repeat (3) @(negedge clk_in);
    lvl(store_out, 3);
  endtask
  task automatic stop();
    lvl(stop_out, 4);
  endtask
  task automatic stop_cycle();
    lvl(pad_out, 20);
  endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench for the OTP programmer
`timescale 1ns/1ns
module tb;
  import smpo_pkg::*;
  localparam int TMO = 3000;
  typedef struct {smpo_state_t st; logic [7:0] dat; logic [7:0] exp;} smpo_row_t;
  smpo_row_t   rows [4] = '{'{SMPO_WORD_A, 8'ha5, 8'ha5}, '{SMPO_WORD_B, 8'h35, 8'h35},
                            '{SMPO_WORD_C, 8'hc3, 8'hc3}, '{SMPO_WORD_A, 8'h5a, 8'hff}};
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        osc_in = 1'b0;
  logic        start, stop, modl, pre, sto, pad_t, pad_w, pad_o, pad_oe_n;
  logic        load_en, stop_mode, reinit, cal;
  smpo_state_t state;
  logic [7:0]  shift, mot_b, mot_c, sel;
  logic [6:0]  inhibit;
  int          fails = 0, compares = 0, cycles = 0, n;
  always #4 clk_in = ~clk_in;
  always @(negedge clk_in) osc_in <= ~osc_in;
  assign pad_w = pad_oe_n ? pad_t : pad_o;
  smpo_station st_u (.clk_in(clk_in), .start_out(start), .stop_out(stop), .mod_out(modl),
    .prestore_out(pre), .store_out(sto), .pad_out(pad_t));
  smpo_programmer #(.SETTLE_CYC_P(50), .TIMEOUT_CYC_P(TMO), .WIN_LO_CYC_P(10),
    .WIN_01_CYC_P(60), .WIN_12_CYC_P(110), .WIN_HI_CYC_P(160), .INH_BASE_CYC_P(200),
    .INH_STEP_CYC_P(4)) dut_u (.CLK_IN(clk_in), .RESET_N_IN(reset_n_in), .OSC_IN(osc_in),
    .START_LVL_IN(start), .STOP_LVL_IN(stop), .MOD_LVL_IN(modl), .PRESTORE_LVL_IN(pre),
    .STORE_LVL_IN(sto), .RESET_PAD_IN(pad_w), .RESET_PAD_OUT(pad_o),
    .RESET_PAD_OE_N_OUT(pad_oe_n), .LOAD_EN_OUT(load_en), .STATE_OUT(state),
    .SHIFT_OUT(shift), .STOP_MODE_OUT(stop_mode), .REINIT_OUT(reinit),
    .INHIBIT_OUT(inhibit), .CAL_PERIOD_OUT(cal), .MOTOR_B_OUT(mot_b), .MOTOR_C_OUT(mot_c));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic settle_wait();
    repeat (8) @(negedge clk_in);
  endtask
  task automatic reload();
    int k;
    fork
      st_u.stop_cycle();
      #80 check(stop_mode, 1'b1);
    join
    for (k = 0; k < 20 && reinit !== 1'b1; k++)
      @(negedge clk_in);
    check(reinit, 1'b1);
    // Word C reaches its output one cycle after the pulse
    @(negedge clk_in);
  endtask
  // Cycles between pad toggles; first loop aligns
  task automatic half(output int c);
    logic v;
    for (int j = 0; j < 2; j++)
    begin
      v = pad_o;
      c = 0;
      while (pad_o === v && c < 4000)
      begin
        @(negedge clk_in);
        c++;
      end
    end
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    repeat (6) @(negedge clk_in);
    check({state, shift, pad_oe_n, load_en}, {SMPO_IDLE, 8'h00, 2'b10});
    reset_n_in = 1'b1;
    repeat (20) @(negedge clk_in);
    foreach (rows[i])
    begin
      st_u.load(rows[i].st, rows[i].dat);
      settle_wait();
      check(state, rows[i].st);
      check(shift, rows[i].dat);
      st_u.commit();
      settle_wait();
      check(state, SMPO_IDLE);
      reload();
      sel = rows[i].st == SMPO_WORD_A ? {inhibit, cal} :
            (rows[i].st == SMPO_WORD_B ? mot_b : mot_c);
      check(sel, rows[i].exp);
    end
    // Walk a single one through word B
    st_u.open(SMPO_WORD_B);
    st_u.gap(135);
    for (int i = 0; i < 8; i++)
    begin
      settle_wait();
      check(shift, 8'h80 >> i);
      check(load_en, rows[1].exp[7 - i]);
      if (i < 7)
        st_u.gap(85);
    end
    st_u.stop();
    settle_wait();
    check(state, SMPO_IDLE);
    // Ignored pulses
    st_u.entry();
    st_u.gap(35);
    st_u.settle();
    st_u.gap(1);
    st_u.gap(200);
    st_u.gap(35);
    settle_wait();
    check(state, SMPO_MEAS_INH);
    repeat (5) st_u.gap(35);
    settle_wait();
    check(state, SMPO_WORD_C);
    repeat (TMO - 150) @(negedge clk_in);
    check(state, SMPO_WORD_C);
    repeat (150) @(negedge clk_in);
    check(state, SMPO_IDLE);
    // 512 oscillator rises span 1024 cycles
    st_u.entry();
    half(n);
    check(n, 1024);
    check({pad_oe_n, load_en}, {1'b0, pad_o});
    st_u.entry();
    settle_wait();
    check(state, SMPO_IDLE);
    st_u.open(SMPO_MEAS_INH);
    half(n);
    check(n, (200 + rows[3].exp[7:1] * 4) / 2);
    st_u.stop();
    settle_wait();
    check(state, SMPO_IDLE);
    conclude();
  end
endmodule

// >>> src/smpo_interval.sv
// Measures spacing between modulation pulses and classifies it
`timescale 1ns/1ns
module smpo_interval
  import smpo_pkg::*;
#(
  parameter int unsigned LO_CYC  = WIN_LO_CYC,
  parameter int unsigned M01_CYC = WIN_01_CYC,
  parameter int unsigned M12_CYC = WIN_12_CYC,
  parameter int unsigned HI_CYC  = WIN_HI_CYC
)(
  input  wire logic clk_in,       // Core clock
  input  wire logic rst_n_in,     // Async reset, active low
  input  wire logic clear_in,     // Drop the timing reference
  input  wire logic pulse_in,     // One-cycle pulse seen
  output logic      advance_out,  // Short spacing: step counter
  output logic      shift_out,    // Medium or long spacing: shift
  output logic      bit_out       // Bit to shift, valid with shift_out
);
  logic [CNT_W-1:0] gap_reg;
  logic             ref_reg;

  // Saturate one count above the top window so long gaps never wrap into one
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      gap_reg <= '0;
    else if (clear_in || pulse_in)
      gap_reg <= '0;
    else if (gap_reg <= CNT_W'(HI_CYC))
      gap_reg <= gap_reg + CNT_W'(1);
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ref_reg <= 1'b0;
    else if (clear_in)
      ref_reg <= 1'b0;
    else if (pulse_in)
      ref_reg <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      advance_out <= 1'b0;
      shift_out   <= 1'b0;
      bit_out     <= 1'b0;
    end
    else
    begin
      advance_out <= 1'b0;
      shift_out   <= 1'b0;
      if (pulse_in && ref_reg && !clear_in &&
          gap_reg >= CNT_W'(LO_CYC) && gap_reg < CNT_W'(HI_CYC))
      begin
        if (gap_reg < CNT_W'(M01_CYC))
          advance_out <= 1'b1;
        else
        begin
          shift_out <= 1'b1;
          bit_out   <= (gap_reg >= CNT_W'(M12_CYC));
        end
      end
    end
  end
endmodule

// >>> src/smpo_otp_array.sv
// Write-once configuration array with registered read port
`timescale 1ns/1ns
module smpo_otp_array
  import smpo_pkg::*;
#(
  parameter int unsigned WORDS = WORD_CNT,
  parameter int unsigned WIDTH = WORD_W
)(
  input  wire logic              clk_in,      // Core clock
  input  wire logic              rst_n_in,    // Async reset, active low
  input  wire logic              wr_en_in,    // Program pulse
  input  wire logic [ADDR_W-1:0] wr_addr_in,  // Word to program
  input  wire logic [WIDTH-1:0]  wr_data_in,  // Bits to burn to 1
  input  wire logic [ADDR_W-1:0] rd_addr_in,  // Word to read
  output logic      [WIDTH-1:0]  rd_data_out  // Registered read data
);
  logic [WIDTH-1:0] cell_reg [WORDS];

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < WORDS; i++)
        cell_reg[i] <= WIDTH'(WORD_RESET);
    end
    else if (wr_en_in && (int'(wr_addr_in) < WORDS))
    begin
      cell_reg[wr_addr_in] <= cell_reg[wr_addr_in] | wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rd_data_out <= '0;
    else if (int'(rd_addr_in) < WORDS)
      rd_data_out <= cell_reg[rd_addr_in];
    else
      rd_data_out <= '0;
  end
endmodule

// >>> src/smpo_programmer.sv
// Supply modulated OTP programming and measurement controller
`timescale 1ns/1ns

// Summary of operation
// - Five states: two measurements, three words
// - Large pulse starts session, then settle
// - Small pulses; first only sets timing
// - Short gap advances instruction counter
// - Medium gap shifts zero, long one
// - Entry sets state one (idle if already in state one), clears shifter
// - Stop pulse or store ends state
// - Two seconds without pulses ends state
// - Pre-store then store burns word
// - Eight-bit shifter: write data, read pointer
// - Leaving stop reloads options, reinitialises
// - State picks word, pointer picks bit
// - Set cell during check loads supply
// - Measurements drive pad and load
// - State two period follows inhibit count
// - State one outputs oscillator over 1024
// - Word A: inhibit count, calibration period
// - Cells go once from zero to one
// - Array holds three eight-bit words
module smpo_programmer
#(
  parameter int unsigned SETTLE_CYC_P   = smpo_pkg::SETTLE_CYC,
  parameter int unsigned TIMEOUT_CYC_P  = smpo_pkg::TIMEOUT_CYC,
  parameter int unsigned WIN_LO_CYC_P   = smpo_pkg::WIN_LO_CYC,
  parameter int unsigned WIN_01_CYC_P   = smpo_pkg::WIN_01_CYC,
  parameter int unsigned WIN_12_CYC_P   = smpo_pkg::WIN_12_CYC,
  parameter int unsigned WIN_HI_CYC_P   = smpo_pkg::WIN_HI_CYC,
  parameter int unsigned INH_BASE_CYC_P = smpo_pkg::INH_BASE_CYC,
  parameter int unsigned INH_STEP_CYC_P = smpo_pkg::INH_STEP_CYC
)(
  input  wire logic                         CLK_IN,            // 125 MHz clock
  input  wire logic                         RESET_N_IN,        // Async reset, active low
  input  wire logic                         OSC_IN,            // Crystal oscillator level
  input  wire logic                         START_LVL_IN,      // Supply above start level
  input  wire logic                         STOP_LVL_IN,       // Supply at stop level
  input  wire logic                         MOD_LVL_IN,        // Small modulation pulse
  input  wire logic                         PRESTORE_LVL_IN,   // Supply at pre-store level
  input  wire logic                         STORE_LVL_IN,      // Supply at store level
  input  wire logic                         RESET_PAD_IN,      // Reset pad level
  output logic                              RESET_PAD_OUT,     // Reset pad drive value
  output logic                              RESET_PAD_OE_N_OUT,// Reset pad enable, low drives
  output logic                              LOAD_EN_OUT,       // Connect supply load
  output smpo_pkg::smpo_state_t             STATE_OUT,         // Instruction state
  output logic [smpo_pkg::WORD_W-1:0]       SHIFT_OUT,         // Shift register
  output logic                              STOP_MODE_OUT,     // Stop mode active
  output logic                              REINIT_OUT,        // Reinitialise pulse
  output logic [smpo_pkg::INH_MSB-smpo_pkg::INH_LSB:0] INHIBIT_OUT, // Pulses to remove
  output logic                              CAL_PERIOD_OUT,    // Calibration period
  output logic [smpo_pkg::WORD_W-1:0]       MOTOR_B_OUT,       // Motor settings word B
  output logic [smpo_pkg::WORD_W-1:0]       MOTOR_C_OUT        // Motor settings word C
);
  import smpo_pkg::*;

  localparam int unsigned INH_W = INH_MSB - INH_LSB + 1;

  function automatic logic [ADDR_W-1:0] word_of(input smpo_state_t s);
    logic [2:0] d;
    d = 3'(s) - 3'(SMPO_WORD_A);
    return d[ADDR_W-1:0];
  endfunction

  function automatic logic is_word(input smpo_state_t s);
    return (s == SMPO_WORD_A) || (s == SMPO_WORD_B) || (s == SMPO_WORD_C);
  endfunction

  // Half period of the inhibit-time signal for a given count
  function automatic logic [PER_W-1:0] inh_half(input logic [INH_W-1:0] n);
    logic [PER_W-1:0] full;
    full = PER_W'(INH_BASE_CYC_P) + PER_W'(n) * PER_W'(INH_STEP_CYC_P);
    return full >> 1;
  endfunction

  smpo_state_t         state_reg;
  smpo_state_t         state_next;
  logic [WORD_W-1:0]   shift_reg;
  logic                start_d_reg;
  logic                stop_d_reg;
  logic                mod_d_reg;
  logic                pre_d_reg;
  logic                store_d_reg;
  logic                osc_d_reg;
  logic                pad_d_reg;
  logic                armed_reg;
  logic                settled_reg;
  logic [CNT_W-1:0]    settle_reg;
  logic [CNT_W-1:0]    quiet_reg;
  logic                meas_reg;
  logic [OSC_HALF_W-1:0] osc_cnt_reg;
  logic [PER_W-1:0]    per_reg;
  logic [2:0]          rl_step_reg;
  logic [WORD_W-1:0]   opt_a_reg;
  logic [WORD_W-1:0]   opt_b_reg;
  logic [WORD_W-1:0]   opt_c_reg;
  logic [WORD_W-1:0]   rd_data;
  logic [ADDR_W-1:0]   rd_addr;
  logic                active;
  logic                start_rise;
  logic                stop_rise;
  logic                mod_rise;
  logic                pre_rise;
  logic                store_rise;
  logic                osc_rise;
  logic                pad_fall;
  logic                commit;
  logic                timeout;
  logic                adv;
  logic                shift_en;
  logic                shift_bit;
  logic                measuring;
  logic                checking;

  assign active     = (state_reg != SMPO_IDLE);
  assign start_rise = START_LVL_IN & ~start_d_reg;
  assign stop_rise  = STOP_LVL_IN & ~stop_d_reg;
  assign mod_rise   = MOD_LVL_IN & ~mod_d_reg;
  assign pre_rise   = PRESTORE_LVL_IN & ~pre_d_reg;
  assign store_rise = STORE_LVL_IN & ~store_d_reg;
  assign osc_rise   = OSC_IN & ~osc_d_reg;
  assign pad_fall   = ~RESET_PAD_IN & pad_d_reg;
  assign measuring  = (state_reg == SMPO_MEAS_OSC) || (state_reg == SMPO_MEAS_INH);
  assign commit     = active & armed_reg & store_rise;
  assign timeout    = active & (quiet_reg >= CNT_W'(TIMEOUT_CYC_P - 1));

  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      start_d_reg <= 1'b0;
      stop_d_reg  <= 1'b0;
      mod_d_reg   <= 1'b0;
      pre_d_reg   <= 1'b0;
      store_d_reg <= 1'b0;
      osc_d_reg   <= 1'b0;
      pad_d_reg   <= 1'b0;
    end
    else
    begin
      start_d_reg <= START_LVL_IN;
      stop_d_reg  <= STOP_LVL_IN;
      mod_d_reg   <= MOD_LVL_IN;
      pre_d_reg   <= PRESTORE_LVL_IN;
      store_d_reg <= STORE_LVL_IN;
      osc_d_reg   <= OSC_IN;
      pad_d_reg   <= RESET_PAD_IN;
    end
  end

  // Ignore modulation until settle time ends
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      settle_reg  <= '0;
      settled_reg <= 1'b0;
    end
    else if (start_rise)
    begin
      settle_reg  <= '0;
      settled_reg <= 1'b0;
    end
    else if (active && !settled_reg)
    begin
      settle_reg  <= settle_reg + CNT_W'(1);
      settled_reg <= (settle_reg >= CNT_W'(SETTLE_CYC_P - 1));
    end
  end

  smpo_interval #(
    .LO_CYC  (WIN_LO_CYC_P),
    .M01_CYC (WIN_01_CYC_P),
    .M12_CYC (WIN_12_CYC_P),
    .HI_CYC  (WIN_HI_CYC_P)
  ) u_interval (
    .clk_in      (CLK_IN),
    .rst_n_in    (RESET_N_IN),
    .clear_in    (start_rise | ~active | ~settled_reg),
    .pulse_in    (mod_rise),
    .advance_out (adv),
    .shift_out   (shift_en),
    .bit_out     (shift_bit)
  );

  // Quiet time since last modulation pulse
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      quiet_reg <= '0;
    else if (start_rise || mod_rise || !active)
      quiet_reg <= '0;
    else
      quiet_reg <= quiet_reg + CNT_W'(1);
  end

  always_comb
  begin
    state_next = state_reg;
    if (start_rise)
      state_next = (state_reg == SMPO_MEAS_OSC) ? SMPO_IDLE : SMPO_MEAS_OSC;
    else if (stop_rise || commit || timeout)
      state_next = SMPO_IDLE;
    else if (adv)
    begin
      unique case (state_reg)
        SMPO_IDLE:     state_next = SMPO_IDLE;
        SMPO_MEAS_OSC: state_next = SMPO_MEAS_INH;
        SMPO_MEAS_INH: state_next = SMPO_WORD_A;
        SMPO_WORD_A:   state_next = SMPO_WORD_B;
        SMPO_WORD_B:   state_next = SMPO_WORD_C;
        SMPO_WORD_C:   state_next = SMPO_WORD_C;
        default:       state_next = SMPO_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      state_reg <= SMPO_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      armed_reg <= 1'b0;
    else if (start_rise || !active || commit)
      armed_reg <= 1'b0;
    else if (pre_rise)
      armed_reg <= 1'b1;
  end

  // Eight-bit shifter, new bit enters at bit 1
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      shift_reg <= '0;
    else if (start_rise)
      shift_reg <= '0;
    // First bit in ends at bit 8
    else if (shift_en && active)
      shift_reg <= {shift_bit, shift_reg[WORD_W-1:1]};
  end

  // Reload reads words A, B, C after reset and on leaving stop mode
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      rl_step_reg <= RL_START;
    else if (pad_fall && !measuring)
      rl_step_reg <= RL_START;
    else if (rl_step_reg != RL_IDLE)
      rl_step_reg <= rl_step_reg + 3'h1;
  end

  // Word from state, bit from pointer
  assign rd_addr = (rl_step_reg < RL_LAST) ? rl_step_reg[ADDR_W-1:0] : word_of(state_reg);

  smpo_otp_array #(
    .WORDS (WORD_CNT),
    .WIDTH (WORD_W)
  ) u_array (
    .clk_in      (CLK_IN),
    .rst_n_in    (RESET_N_IN),
    .wr_en_in    (commit & is_word(state_reg)),
    .wr_addr_in  (word_of(state_reg)),
    .wr_data_in  (shift_reg),
    .rd_addr_in  (rd_addr),
    .rd_data_out (rd_data)
  );

  // Word A carries inhibit count and period
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      opt_a_reg  <= WORD_RESET;
      opt_b_reg  <= WORD_RESET;
      opt_c_reg  <= WORD_RESET;
      REINIT_OUT <= 1'b0;
    end
    else
    begin
      if (rl_step_reg == RL_START + 3'h1)
        opt_a_reg <= rd_data;
      if (rl_step_reg == RL_START + 3'h2)
        opt_b_reg <= rd_data;
      if (rl_step_reg == RL_LAST)
        opt_c_reg <= rd_data;
      REINIT_OUT <= (rl_step_reg == RL_LAST);
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      osc_cnt_reg <= '0;
      per_reg     <= '0;
      meas_reg    <= 1'b0;
    end
    else if (state_reg != state_next)
    begin
      osc_cnt_reg <= '0;
      per_reg     <= '0;
      meas_reg    <= 1'b0;
    end
    else if (state_reg == SMPO_MEAS_OSC)
    begin
      if (osc_rise)
      begin
        osc_cnt_reg <= osc_cnt_reg + OSC_HALF_W'(1);
        if (osc_cnt_reg == OSC_HALF_W'(OSC_DIV / 2 - 1))
          meas_reg <= ~meas_reg;
      end
    end
    else if (state_reg == SMPO_MEAS_INH)
    begin
      if (per_reg >= inh_half(opt_a_reg[INH_MSB:INH_LSB]) - PER_W'(1))
      begin
        per_reg  <= '0;
        meas_reg <= ~meas_reg;
      end
      else
        per_reg <= per_reg + PER_W'(1);
    end
  end

  // Pointer is valid only while one-hot
  assign checking = is_word(state_reg) && $onehot(shift_reg) && (rl_step_reg == RL_IDLE)
                    && (rd_addr == word_of(state_reg));

  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      RESET_PAD_OUT      <= 1'b0;
      RESET_PAD_OE_N_OUT <= 1'b1;
      LOAD_EN_OUT        <= 1'b0;
    end
    else
    begin
      RESET_PAD_OUT      <= measuring & meas_reg;
      RESET_PAD_OE_N_OUT <= ~measuring;
      if (checking)
        LOAD_EN_OUT <= |(rd_data & shift_reg);
      else
        LOAD_EN_OUT <= measuring & meas_reg;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      STOP_MODE_OUT  <= 1'b0;
      STATE_OUT      <= SMPO_IDLE;
      SHIFT_OUT      <= '0;
      INHIBIT_OUT    <= '0;
      CAL_PERIOD_OUT <= 1'b0;
      MOTOR_B_OUT    <= '0;
      MOTOR_C_OUT    <= '0;
    end
    else
    begin
      STOP_MODE_OUT  <= pad_d_reg & ~measuring;
      STATE_OUT      <= state_reg;
      SHIFT_OUT      <= shift_reg;
      INHIBIT_OUT    <= opt_a_reg[INH_MSB:INH_LSB];
      CAL_PERIOD_OUT <= opt_a_reg[CAL_POS];
      MOTOR_B_OUT    <= opt_b_reg;
      MOTOR_C_OUT    <= opt_c_reg;
    end
  end
endmodule
